// File: inc/tgr_pkg.sv
// Package for the tap gesture recognizer: register map, flags, timing and carriers
package tgr_pkg;

    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_ZONE_LEFT   = 12'h540;
    localparam logic [11:0] IDX_ZONE_RIGHT  = 12'h541;
    localparam logic [11:0] IDX_ZONE_TOP    = 12'h542;
    localparam logic [11:0] IDX_ZONE_BOTTOM = 12'h543;
    localparam logic [11:0] IDX_HOLD_LIMIT  = 12'h544;
    localparam logic [11:0] IDX_REPEAT_WIN  = 12'h545;
    localparam logic [11:0] IDX_CONTROL     = 12'h546;
    localparam logic [11:0] IDX_STATUS      = 12'h547;

    localparam int ADDR_W = 14;

    localparam logic [15:0] RST_ZONE_LEFT   = 16'h0100;
    localparam logic [15:0] RST_ZONE_RIGHT  = 16'h1300;
    localparam logic [15:0] RST_ZONE_TOP    = 16'h0100;
    localparam logic [15:0] RST_ZONE_BOTTOM = 16'h2300;
    localparam logic [31:0] RST_HOLD_LIMIT  = 32'h00007a12;
    localparam logic [31:0] RST_REPEAT_WIN  = 32'h0001312d;
    localparam logic [1:0]  RST_CONTROL     = 2'h3;

    // Control bits
    localparam int CTL_ENABLE_BIT = 0;
    localparam int CTL_OUTPUT_BIT = 1;

    // Message
    localparam logic [7:0] MSG_ID_TAP = 8'ha2;

    // Flag encodings
    localparam logic [7:0] FLAG_SEEN     = 8'h01;
    localparam logic [7:0] FLAG_ABORT    = 8'h02;
    localparam logic [7:0] FLAG_ISOLATED = 8'h04;
    localparam logic [7:0] FLAG_REPEATED = 8'h08;
    localparam logic [7:0] FLAG_SAME_CNT = 8'h10;

    // Timebase: one tick is 1 s / 156250 = 6400 ns
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_NS       = 6400;
    // Last prescaler count of a tick; 256 clocks fit an 8-bit count of 0 to 255, so wrap after the end value
    localparam logic [7:0] TICK_LAST   = 8'(TICK_NS / CLK_PERIOD_NS - 1);

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_TOUCH = 4'b0010,
        ST_DEAD  = 4'b0100,
        ST_SEND  = 4'b1000
    } tgr_state_type;

    typedef struct packed {
        logic        valid;
        logic [3:0]  count;
        logic        in_zone_any;
    } tgr_contact_type;

    typedef struct packed {
        logic [7:0] id;
        logic [7:0] flags;
        logic [7:0] fingers;
    } tgr_msg_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
        logic              wr;
        logic              rd;
    } tgr_bus_req_type;

endpackage : tgr_pkg

// File: rtl/tgr_tap_recognizer.sv
// Tap gesture recognizer: timing, zone check, flag building and register file
// Operation
// [R1] Touch start launches hold timer; expiry while down abandons that touch.
// [R2] All fingers lifted before hold limit expiry makes a recognized tap.
// [R3] Recognized tap starts repeat window; touch starting inside it is repeated.
// [R4] Recognition starts only if a finger lies inside the zone rectangle.
// [R5] Zone bounds at 0x540-0x543, hold limit 0x544, repeat window 0x545.
// [R6] Timeouts count 1/156250 s ticks; defaults 31250 and 78125.
// [R7] Zone compares raw coordinates; defaults 256, 4864, 256, 8960.
// [R8] Tap message is id 0xA2, then flag byte, then finger count.
// [R9] Flags OR together: seen 01, abort 02, isolated 04, repeated 08, same 10.
// [R10] With seen flag, finger count holds fingers used for the tap.
// [R11] Abort flag marks hold expiry; finger count then not valid.
// [R12] Repeated flag when within repeat window, otherwise isolated flag.
// [R13] Same-count flag when previous tap used the same finger count.
// [R14] Recognize only when enabled; emit only when output mask bit set.
// [R15] One message per tap or abort; count is peak simultaneous contacts.
module tgr_tap_recognizer (
    input  wire logic                          clk,
    input  wire logic                          reset,
    input  wire logic                          contact_valid,
    input  wire logic [3:0]                    contact_count,
    input  wire logic [15:0]                   contact_x,
    input  wire logic [15:0]                   contact_y,
    input  wire logic [tgr_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic [31:0]                   reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic [31:0]                        reg_rdata,
    output logic                               msg_valid,
    output tgr_pkg::tgr_msg_type               msg
);

    // Contact inputs arrive one per cycle from the tracking front end (same clock)
    typedef struct packed {
        tgr_pkg::tgr_state_type st;
        logic [15:0]            zl;
        logic [15:0]            zr;
        logic [15:0]            zt;
        logic [15:0]            zb;
        logic [31:0]            hold_lim;
        logic [31:0]            rep_lim;
        logic [1:0]             ctl;
        logic [7:0]             prescale;
        logic [31:0]            hold_cnt;
        logic [31:0]            rep_cnt;
        logic                   rep_run;
        logic                   cur_repeat;
        logic [3:0]             peak;
        logic [3:0]             last_count;
        logic                   have_last;
        logic                   prev_down;
        logic [7:0]             flags;
        logic [7:0]             fingers;
        logic                   msg_valid;
        tgr_pkg::tgr_msg_type   msg;
        logic [31:0]            rdata;
        logic [7:0]             tap_total;
    } tgr_state_all_type;

    tgr_state_all_type s_q;
    tgr_state_all_type s_d;

    function automatic logic in_zone(input logic [15:0] x, input logic [15:0] y,
                                     input logic [15:0] l, input logic [15:0] r,
                                     input logic [15:0] t, input logic [15:0] b);
        in_zone = (x >= l) && (x <= r) && (y >= t) && (y <= b);
    endfunction : in_zone

    localparam int ADDR_IDX_W = tgr_pkg::ADDR_W - 2;

    function automatic logic [ADDR_IDX_W-1:0] word_index(input logic [tgr_pkg::ADDR_W-1:0] a);
        word_index = a[tgr_pkg::ADDR_W-1:2];
    endfunction : word_index

    logic        tick;
    logic        down;
    logic        finger_in;
    logic [11:0] widx;

    always_comb begin
        tick      = (s_q.prescale == tgr_pkg::TICK_LAST);
        down      = contact_valid && (contact_count != 4'h0);
        finger_in = down && in_zone(contact_x, contact_y, s_q.zl, s_q.zr, s_q.zt, s_q.zb); // [R4] [R7]
        widx      = word_index(reg_addr);
    end

    always_comb begin
        s_d           = s_q;
        s_d.msg_valid = 1'b0;
        s_d.prescale  = tick ? 8'h00 : s_q.prescale + 8'h01; // [R6]

        // Register writes
        if (reg_wr) begin
            unique case (widx)
                tgr_pkg::IDX_ZONE_LEFT:   s_d.zl = reg_wdata[15:0]; // [R5]
                tgr_pkg::IDX_ZONE_RIGHT:  s_d.zr = reg_wdata[15:0];
                tgr_pkg::IDX_ZONE_TOP:    s_d.zt = reg_wdata[15:0];
                tgr_pkg::IDX_ZONE_BOTTOM: s_d.zb = reg_wdata[15:0];
                tgr_pkg::IDX_HOLD_LIMIT:  s_d.hold_lim = reg_wdata;
                tgr_pkg::IDX_REPEAT_WIN:  s_d.rep_lim  = reg_wdata;
                tgr_pkg::IDX_CONTROL:     s_d.ctl      = reg_wdata[1:0];
                default: ;
            endcase
        end

        // Register reads, answered in the next cycle; unmapped reads as zero
        s_d.rdata = 32'h00000000;
        if (reg_rd) begin
            unique case (widx)
                tgr_pkg::IDX_ZONE_LEFT:   s_d.rdata = {16'h0000, s_q.zl};
                tgr_pkg::IDX_ZONE_RIGHT:  s_d.rdata = {16'h0000, s_q.zr};
                tgr_pkg::IDX_ZONE_TOP:    s_d.rdata = {16'h0000, s_q.zt};
                tgr_pkg::IDX_ZONE_BOTTOM: s_d.rdata = {16'h0000, s_q.zb};
                tgr_pkg::IDX_HOLD_LIMIT:  s_d.rdata = s_q.hold_lim;
                tgr_pkg::IDX_REPEAT_WIN:  s_d.rdata = s_q.rep_lim;
                tgr_pkg::IDX_CONTROL:     s_d.rdata = {30'h00000000, s_q.ctl};
                tgr_pkg::IDX_STATUS:      s_d.rdata = {8'h00, s_q.tap_total, 4'h0, s_q.st,
                                                       3'h0, s_q.rep_run, s_q.peak};
                default:                  s_d.rdata = 32'h00000000;
            endcase
        end

        // Repeat window runs independently of touch state
        if (s_q.rep_run && tick) begin
            if (s_q.rep_cnt + 32'h00000001 >= s_q.rep_lim) begin
                s_d.rep_run = 1'b0; // [R3]
            end
            s_d.rep_cnt = s_q.rep_cnt + 32'h00000001;
        end

        s_d.prev_down = down;

        unique case (s_q.st)
            tgr_pkg::ST_IDLE: begin
                // Only a fresh contact opens a touch; a touch held across enable is ignored
                if (s_q.ctl[tgr_pkg::CTL_ENABLE_BIT] && finger_in && !s_q.prev_down) begin // [R14] [R4]
                    s_d.st         = tgr_pkg::ST_TOUCH;
                    s_d.hold_cnt   = 32'h00000000; // [R1]
                    s_d.cur_repeat = s_q.rep_run;  // [R3]
                    s_d.peak       = contact_count;
                end
            end
            tgr_pkg::ST_TOUCH: begin
                if (!down) begin
                    // Tap recognized: build message and arm the repeat window
                    s_d.flags = tgr_pkg::FLAG_SEEN // [R2] [R9]
                              | (s_q.cur_repeat ? tgr_pkg::FLAG_REPEATED : tgr_pkg::FLAG_ISOLATED) // [R12]
                              | ((s_q.have_last && s_q.last_count == s_q.peak)
                                 ? tgr_pkg::FLAG_SAME_CNT : 8'h00); // [R13]
                    s_d.fingers    = {4'h0, s_q.peak}; // [R10] [R15]
                    s_d.last_count = s_q.peak;
                    s_d.have_last  = 1'b1;
                    s_d.rep_run    = 1'b1; // [R3]
                    s_d.rep_cnt    = 32'h00000000;
                    s_d.tap_total  = s_q.tap_total + 8'h01;
                    s_d.st         = tgr_pkg::ST_SEND;
                end else begin
                    if (contact_count > s_q.peak) begin
                        s_d.peak = contact_count; // [R15]
                    end
                    if (tick) begin
                        s_d.hold_cnt = s_q.hold_cnt + 32'h00000001;
                        if (s_q.hold_cnt + 32'h00000001 >= s_q.hold_lim) begin
                            s_d.flags   = tgr_pkg::FLAG_ABORT; // [R11] [R1]
                            s_d.fingers = 8'h00;
                            s_d.st      = tgr_pkg::ST_SEND;
                        end
                    end
                end
            end
            tgr_pkg::ST_SEND: begin
                if (s_q.ctl[tgr_pkg::CTL_OUTPUT_BIT]) begin // [R14]
                    s_d.msg_valid   = 1'b1; // [R15]
                    s_d.msg.id      = tgr_pkg::MSG_ID_TAP; // [R8]
                    s_d.msg.flags   = s_q.flags;
                    s_d.msg.fingers = s_q.fingers;
                end
                // After an abort the fingers are still down: wait for lift
                s_d.st = (s_q.flags == tgr_pkg::FLAG_ABORT) ? tgr_pkg::ST_DEAD : tgr_pkg::ST_IDLE;
            end
            tgr_pkg::ST_DEAD: begin
                if (!down) begin
                    s_d.st = tgr_pkg::ST_IDLE; // [R1]
                end
            end
            default: s_d.st = tgr_pkg::ST_IDLE;
        endcase

        // Disabling drops a touch in progress without reporting it
        if (!s_q.ctl[tgr_pkg::CTL_ENABLE_BIT] && s_q.st == tgr_pkg::ST_TOUCH) begin // [R14]
            s_d.st = tgr_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q            <= '0;
            s_q.st         <= tgr_pkg::ST_IDLE;
            s_q.zl         <= tgr_pkg::RST_ZONE_LEFT; // [R7]
            s_q.zr         <= tgr_pkg::RST_ZONE_RIGHT;
            s_q.zt         <= tgr_pkg::RST_ZONE_TOP;
            s_q.zb         <= tgr_pkg::RST_ZONE_BOTTOM;
            s_q.hold_lim   <= tgr_pkg::RST_HOLD_LIMIT; // [R6]
            s_q.rep_lim    <= tgr_pkg::RST_REPEAT_WIN;
            s_q.ctl        <= tgr_pkg::RST_CONTROL;
            s_q.prev_down  <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        reg_rdata = s_q.rdata;
        msg_valid = s_q.msg_valid;
        msg       = s_q.msg;
    end

endmodule : tgr_tap_recognizer

// File: testbench/tgr_checker.sv
// Port assertions for the tap gesture recognizer
module tgr_checker (
    input wire logic                 clk,
    input wire logic                 reset,
    input wire logic                 contact_valid,
    input wire logic [3:0]           contact_count,
    input wire logic                 reg_rd,
    input wire logic [31:0]          reg_rdata,
    input wire logic                 msg_valid,
    input wire tgr_pkg::tgr_msg_type msg
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    a_msg_pulse: assert property (msg_valid |=> !msg_valid)
        else $error("message pulse too long");
    a_msg_id: assert property (msg_valid |-> msg.id == 8'ha2)
        else $error("bad message id");
    a_seen_abort: assert property (msg_valid |-> msg.flags[0] != msg.flags[1])
        else $error("seen and abort not exclusive");
    a_abort_fingers: assert property (msg_valid && msg.flags[1] |-> msg.fingers == 8'h00)
        else $error("abort carries fingers");
    a_tap_fingers: assert property (msg_valid && msg.flags[0] |-> msg.fingers inside {[1:15]})
        else $error("tap finger count out of range");
    a_tap_lift: assert property (msg_valid && msg.flags[0] |-> $past(!contact_valid || contact_count == 4'h0, 2))
        else $error("tap without lift two cycles before");
    a_msg_hold: assert property (!msg_valid |-> $stable(msg))
        else $error("message changed without pulse");
endmodule : tgr_checker

bind tgr_tap_recognizer tgr_checker u_chk (.clk(clk), .reset(reset), .contact_valid(contact_valid),
    .contact_count(contact_count), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .msg_valid(msg_valid), .msg(msg));

// File: testbench/tgr_host_model.sv
// Host-side model that collects tap messages
module tgr_host_model (
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic                 msg_valid,
    input  wire tgr_pkg::tgr_msg_type msg,
    output logic [7:0]                rx_count,
    output tgr_pkg::tgr_msg_type      rx_last
);
    // The host takes the message in the pulse cycle only; a missed pulse is a lost message
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_count <= 8'h00;
            rx_last  <= '0;
        end else if (msg_valid) begin
            rx_count <= rx_count + 8'h01;
            rx_last  <= msg;
        end
    end
endmodule : tgr_host_model

// File: testbench/tb.sv
// Self-checking testbench for the tap gesture recognizer
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 clk = 1'b0;
    logic                 reset = 1'b1;
    logic                 contact_valid = 1'b0;
    logic [3:0]           contact_count = 4'h0;
    logic [15:0]          contact_x = 16'h0000;
    logic [15:0]          contact_y = 16'h0200;
    logic [13:0]          reg_addr = 14'h0000;
    logic [31:0]          reg_wdata = 32'h0;
    logic                 reg_wr = 1'b0;
    logic                 reg_rd = 1'b0;
    logic [31:0]          reg_rdata;
    logic                 msg_valid;
    tgr_pkg::tgr_msg_type msg;
    tgr_pkg::tgr_msg_type rx_last;
    logic [7:0]           rx_count;
    int                   fail_count = 0;
    int                   num_checks = 0;

    initial forever #12.5 clk = ~clk;

    tgr_tap_recognizer u_dut (.clk(clk), .reset(reset), .contact_valid(contact_valid),
        .contact_count(contact_count), .contact_x(contact_x), .contact_y(contact_y), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .msg_valid(msg_valid), .msg(msg));
    tgr_host_model u_host (.clk(clk), .reset(reset), .msg_valid(msg_valid), .msg(msg),
        .rx_count(rx_count), .rx_last(rx_last));

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [11:0] idx, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= {idx, 2'b00};
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] idx, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= {idx, 2'b00};
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    // Press n fingers for len cycles, lift, and count the messages seen
    task automatic touch(input logic [15:0] x, input logic [3:0] n, input int len, output logic [7:0] got);
        logic [7:0] n0;
        n0 = rx_count;
        @(posedge clk);
        contact_valid <= 1'b1;
        contact_count <= n;
        contact_x     <= x;
        repeat (len) @(posedge clk);
        contact_valid <= 1'b0;
        contact_count <= 4'h0;
        repeat (8) @(posedge clk);
        #1 got = rx_count - n0;
    endtask : touch

    task automatic t_regs();
        logic [31:0] d;
        logic [31:0] dflt [6] = '{32'h100, 32'h1300, 32'h100, 32'h2300, 32'h7a12, 32'h1312d};
        for (int i = 0; i < 6; i++) begin
            rd(12'h540 + 12'(i), d);
            chk("default", dflt[i], d);
        end
        rd(12'h548, d);
        chk("unmapped", 32'h0, d);
        // Short limits keep the run small: hold 2 ticks, window 4 ticks
        wr(12'h544, 32'h2);
        wr(12'h545, 32'h4);
        rd(12'h544, d);
        chk("hold limit", 32'h2, d);
        $display("t_regs done");
    endtask : t_regs

    task automatic t_taps();
        logic [7:0]  g;
        logic [3:0]  n [4] = '{4'h1, 4'h2, 4'h2, 4'h2};
        int          gap [4] = '{0, 0, 0, 1400};
        logic [31:0] e [4] = '{32'ha20501, 32'ha20902, 32'ha21902, 32'ha21502};
        for (int i = 0; i < 4; i++) begin
            repeat (gap[i]) @(posedge clk);
            touch(16'h0200, n[i], 20, g);
            chk("tap msg", e[i], {8'h00, rx_last});
        end
        $display("t_taps done");
    endtask : t_taps

    task automatic t_abort();
        logic [7:0] g;
        touch(16'h0200, 4'h3, 900, g);
        chk("abort count", 32'h1, {24'h0, g});
        chk("abort msg", 32'ha20200, {8'h00, rx_last.id, 6'h0, rx_last.flags[1:0], rx_last.fingers});
        $display("t_abort done");
    endtask : t_abort

    task automatic t_zone();
        logic [7:0]  g;
        logic [15:0] xs [4] = '{16'h00ff, 16'h0100, 16'h1301, 16'h1300};
        logic [7:0]  e [4] = '{8'h0, 8'h1, 8'h0, 8'h1};
        for (int i = 0; i < 4; i++) begin
            touch(xs[i], 4'h1, 20, g);
            chk("zone", {24'h0, e[i]}, {24'h0, g});
        end
        $display("t_zone done");
    endtask : t_zone

    task automatic t_mask();
        logic [7:0]  g;
        logic [31:0] c [3] = '{32'h1, 32'h0, 32'h3};
        for (int i = 0; i < 3; i++) begin
            wr(12'h546, c[i]);
            touch(16'h0200, 4'h1, 20, g);
            chk("mask", {31'h0, c[i][1]}, {24'h0, g});
        end
        $display("t_mask done");
    endtask : t_mask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_taps();
        t_abort();
        t_zone();
        t_mask();
        stop_test();
    end

    // The run needs about 2700 cycles; a hang is cut off well beyond that
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        stop_test();
    end
endmodule : tb
